/* File: pkg/blit_rop_pkg.sv */
// Constants, carriers and lookup for the raster-operation stage
package blit_rop_pkg;

  // ****************************************
  // Register offsets and reset values
  // ****************************************
  localparam logic [7:0] OFF_ROP = 8'h1A;
  localparam logic [7:0] OFF_EXT = 8'h1B;
  localparam logic [7:0] OFF_KEYLO = 8'h1C;
  localparam logic [7:0] OFF_KEYHI = 8'h1D;
  localparam logic [7:0] RST_ROP = 8'h06;
  localparam logic [4:0] RST_EXT = 5'h00;
  localparam logic [7:0] RST_KEY = 8'h00;
  localparam logic [7:0] RD_NONE = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int EXT_W = 5;
  localparam int EXT_SYNC = 4;
  localparam int EXT_BGCLIP = 3;
  localparam int EXT_SOLID = 2;
  localparam int EXT_INV = 1;
  localparam int EXT_GRAN = 0;
  localparam int MODE_CEXP = 7;
  localparam int MODE_TRANSP = 3;
  localparam int MODE_SYS = 2;
  localparam int DBC_WREN = 5;
  localparam logic [2:0] DBC_SWITCH = 3'h7;
  localparam int PIX_W = 16;
  localparam int BYTE_W = 8;

  // ****************************************
  // Scanline-end discard masks
  // ****************************************
  localparam logic [4:0] MASK_BYTE = 5'h07;
  localparam logic [4:0] MASK_DWORD = 5'h1F;
  localparam logic [4:0] POS_ZERO = 5'h00;

  // ****************************************
  // Operation codes
  // ****************************************
  localparam logic [7:0] ROP_ZERO = 8'h00;
  localparam logic [7:0] ROP_ONE = 8'h0E;
  localparam logic [7:0] ROP_DST = 8'h06;
  localparam logic [7:0] ROP_SRC = 8'h0D;
  localparam logic [7:0] ROP_NSRC = 8'hD0;
  localparam logic [7:0] ROP_NDST = 8'h0B;
  localparam logic [7:0] ROP_AND = 8'h05;
  localparam logic [7:0] ROP_OR = 8'h6D;
  localparam logic [7:0] ROP_XOR = 8'h59;
  localparam logic [7:0] ROP_NAND = 8'hDA;
  localparam logic [7:0] ROP_NOR = 8'h90;
  localparam logic [7:0] ROP_XNOR = 8'h95;
  localparam logic [7:0] ROP_NSAND = 8'h50;
  localparam logic [7:0] ROP_SANDN = 8'h09;
  localparam logic [7:0] ROP_NSOR = 8'hD6;
  localparam logic [7:0] ROP_SORN = 8'hAD;

  // Truth tables indexed by {source bit, destination bit}
  typedef logic [3:0] truth_t;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [PIX_W-1:0] src;
    logic [PIX_W-1:0] dst;
    logic [PIX_W-1:0] fg;
    logic [PIX_W-1:0] bg;
    logic mono;
    logic clip_blk;
    logic bpp16;
  } pix_in_s;

  typedef struct packed {
    logic [PIX_W-1:0] data;
    logic we;
  } pix_out_s;

  // Code to truth table; unknown codes keep the destination
  function automatic truth_t rop_table(input logic [7:0] code);
    truth_t t;
    t = 4'hA;
    case (code)
      ROP_ZERO: t = 4'h0;
      ROP_ONE: t = 4'hF;
      ROP_DST: t = 4'hA;
      ROP_SRC: t = 4'hC;
      ROP_NSRC: t = 4'h3;
      ROP_NDST: t = 4'h5;
      ROP_AND: t = 4'h8;
      ROP_OR: t = 4'hE;
      ROP_XOR: t = 4'h6;
      ROP_NAND: t = 4'h7;
      ROP_NOR: t = 4'h1;
      ROP_XNOR: t = 4'h9;
      ROP_NSAND: t = 4'h2;
      ROP_SANDN: t = 4'h4;
      ROP_NSOR: t = 4'hB;
      ROP_SORN: t = 4'hD;
      default: t = 4'hA;
    endcase
    return t;
  endfunction

endpackage

/* File: logic/blit_rop_transparency_ext.sv */
// Raster operation and write qualification stage of the block transfer engine

module blit_rop_transparency_ext
  import blit_rop_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [7:0] blit_mode_control_i,
  input wire logic autostart_en_i,
  input wire logic [7:0] double_buffer_control_i,
  input wire logic blit_done_i,
  input wire logic pix_valid_i,
  input wire pix_in_s pix_i,
  output logic pix_valid_o,
  output pix_out_s pix_o,
  input wire logic line_end_i,
  input wire logic [4:0] src_bit_pos_i,
  output logic skip_valid_o,
  output logic [4:0] skip_bits_o,
  output logic disp_buf_sel_o
);

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] rop_q;
  logic [EXT_W-1:0] ext_q;
  logic [7:0] key_lo_q;
  logic [7:0] key_hi_q;
  logic [7:0] rdata_q;

  // Address decode and write qualification
  wire logic sel_rop = reg_addr_i == OFF_ROP;
  wire logic sel_ext = reg_addr_i == OFF_EXT;
  wire logic sel_klo = reg_addr_i == OFF_KEYLO;
  wire logic sel_khi = reg_addr_i == OFF_KEYHI;
  wire logic ext_open = autostart_en_i & double_buffer_control_i[DBC_WREN];
  wire logic wr_ext = reg_wr_i & sel_ext & ext_open;

  // Read mux; reserved extension bits read zero
  wire logic [7:0] rd_mux =
    sel_rop ? rop_q :
    sel_ext ? {{(8-EXT_W){1'b0}}, ext_q} :
    sel_klo ? key_lo_q :
    sel_khi ? key_hi_q : RD_NONE;

  // Register writes
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rop_q <= RST_ROP;
      ext_q <= RST_EXT;
      key_lo_q <= RST_KEY;
      key_hi_q <= RST_KEY;
    end else begin
      if (reg_wr_i && sel_rop) rop_q <= reg_wdata_i;
      if (wr_ext) ext_q <= reg_wdata_i[EXT_W-1:0];
      if (reg_wr_i && sel_klo) key_lo_q <= reg_wdata_i;
      if (reg_wr_i && sel_khi) key_hi_q <= reg_wdata_i;
    end
  end

  // Read data is captured one edge after the read strobe
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) rdata_q <= RD_NONE;
    else if (reg_rd_i) rdata_q <= rd_mux;
  end

  assign reg_rdata_o = rdata_q;

  // ****************************************
  // Mode decode
  // ****************************************
  wire logic cexp = blit_mode_control_i[MODE_CEXP];
  wire logic transp = blit_mode_control_i[MODE_TRANSP];
  wire logic sys_src = blit_mode_control_i[MODE_SYS];
  wire logic solid = ext_q[EXT_SOLID];
  wire logic bgclip = ext_q[EXT_BGCLIP];
  wire logic inv = ext_q[EXT_INV];
  wire logic gran = ext_q[EXT_GRAN];
  wire logic sync_sw = ext_q[EXT_SYNC];

  // ****************************************
  // Operand selection
  // ****************************************
  // Transparent expansion may flip the sense of the bitmap bit
  wire logic mono_eff = (transp & inv) ? ~pix_i.mono : pix_i.mono;
  // Solid fill forces every expanded bit to foreground
  wire logic fg_bit = solid | (mono_eff);
  // Expanded pixel replaces source or pattern operand
  wire logic [PIX_W-1:0] operand =
    cexp ? (fg_bit ? pix_i.fg : pix_i.bg) : pix_i.src;
  wire truth_t tt = rop_table(rop_q);

  // Apply the function to each bit independently
  logic [PIX_W-1:0] rop_res;
  genvar gi;
  generate
    for (gi = 0; gi < PIX_W; gi++) begin : g_bit
      assign rop_res[gi] = tt[{operand[gi], pix_i.dst[gi]}];
    end
  endgenerate
  // Individual codes are covered by the table above

  // ****************************************
  // Write qualification
  // ****************************************
  // Transparent expansion leaves bits that expand to background unwritten
  wire logic exp_skip = cexp & transp & ~fg_bit;
  // Background-only clipping still lets foreground through
  wire logic clip_skip = pix_i.clip_blk & ~(cexp & bgclip & fg_bit);
  // Key colour built from low then high byte
  wire logic [PIX_W-1:0] key = {key_hi_q, key_lo_q};
  wire logic key_lo_hit = rop_res[BYTE_W-1:0] == key[BYTE_W-1:0];
  wire logic key_hi_hit = rop_res[PIX_W-1:BYTE_W] == key[PIX_W-1:BYTE_W];
  wire logic key_hit = key_lo_hit & (key_hi_hit | ~pix_i.bpp16);
  wire logic key_skip = transp & ~cexp & key_hit;
  wire logic we_d = ~(exp_skip | clip_skip | key_skip);

  // Output pixel stage
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pix_valid_o <= 1'b0;
      pix_o <= '0;
    end else begin
      pix_valid_o <= pix_valid_i;
      if (pix_valid_i) begin
        pix_o.data <= rop_res;
        pix_o.we <= we_d;
      end
    end
  end

  // ****************************************
  // Scanline-end source discard
  // ****************************************
  // Byte end only for expanded blits with granularity clear
  wire logic [4:0] skip_mask =
    (cexp & ~gran) ? MASK_BYTE : MASK_DWORD;
  wire logic [4:0] skip_d = (POS_ZERO - src_bit_pos_i) & skip_mask;

  // Discard count reported at each system-source line end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      skip_valid_o <= 1'b0;
      skip_bits_o <= POS_ZERO;
    end else begin
      skip_valid_o <= line_end_i & sys_src;
      if (line_end_i && sys_src) skip_bits_o <= skip_d;
    end
  end

  // ****************************************
  // Display buffer switching
  // ****************************************
  wire logic sw_mode = double_buffer_control_i[2:0] == DBC_SWITCH;
  wire logic do_switch = blit_done_i & sync_sw & sw_mode;

  // Zero selects buffer at location zero, one selects screen start A
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) disp_buf_sel_o <= 1'b0;
    else if (do_switch) disp_buf_sel_o <= ~disp_buf_sel_o;
  end

  // ****************************************
  // Checks
  // ****************************************
  wire logic plain = pix_valid_i & ~cexp & ~transp & ~pix_i.clip_blk;

  // Zero code clears the pixel
  a_rop_zero_out: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    plain && rop_q == ROP_ZERO |=> pix_o.data == '0 && pix_o.we)
    else $error("zero code did not write zeros");

  // Copy code passes the operand
  a_rop_src_copy: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    plain && rop_q == ROP_SRC |=> pix_o.data == $past(pix_i.src))
    else $error("copy code did not pass source");

  // Exclusive-or code
  a_rop_xor_out: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    plain && rop_q == ROP_XOR |=> pix_o.data == ($past(pix_i.src) ^ $past(pix_i.dst)))
    else $error("xor code gave wrong pixel");

  // Inverted source with destination
  a_rop_nsand_out: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    plain && rop_q == ROP_NSAND |=> pix_o.data == (~$past(pix_i.src) & $past(pix_i.dst)))
    else $error("inverted-source and gave wrong pixel");

  // Locked extension register ignores writes
  a_ext_locked_write: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    reg_wr_i && sel_ext && !ext_open |=> $stable(ext_q))
    else $error("locked extension register changed");

  // Buffer toggles after a switching blit completes
  a_disp_toggle_done: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    blit_done_i && sync_sw && sw_mode |=> disp_buf_sel_o != $past(disp_buf_sel_o))
    else $error("display buffer did not toggle");

  // Normal clipping blocks every pixel
  a_clip_blocks_all: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    pix_valid_i && pix_i.clip_blk && !bgclip |=> pix_valid_o && !pix_o.we)
    else $error("clipped pixel was written");

  // Solid fill with copy code writes foreground
  a_solid_fill_fg: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    pix_valid_i && cexp && solid && !pix_i.clip_blk && rop_q == ROP_SRC
    |=> pix_o.we && pix_o.data == $past(pix_i.fg))
    else $error("solid fill did not write foreground");

  // Inverted sense leaves one bits unwritten
  a_inv_sense_skip: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    pix_valid_i && cexp && transp && inv && !solid && pix_i.mono |=> !pix_o.we)
    else $error("inverted sense wrote a one bit");

  // Dword granularity discard count
  a_gran_dword_skip: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    line_end_i && sys_src && cexp && gran
    |=> skip_valid_o && skip_bits_o == ((POS_ZERO - $past(src_bit_pos_i)) & MASK_DWORD))
    else $error("dword discard count wrong");

  // Byte granularity never passes seven bits
  a_gran_byte_skip: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    line_end_i && sys_src && cexp && !gran |=> skip_bits_o <= MASK_BYTE)
    else $error("byte discard exceeded byte");

  // Key match suppresses a 16-bit write
  a_key_match_skip: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    pix_valid_i && transp && !cexp && pix_i.bpp16 && rop_q == ROP_DST
    && pix_i.dst == key |=> !pix_o.we)
    else $error("key colour match was written");

  // One code writes all ones
  a_rop_one_out: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    plain && rop_q == ROP_ONE |=> pix_o.data == '1 && pix_o.we)
    else $error("one code did not write ones");

  // Keep code leaves the destination
  a_rop_dst_keep: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    plain && rop_q == ROP_DST |=> pix_o.data == $past(pix_i.dst))
    else $error("keep code changed destination");

  // Inverted source code
  a_rop_nsrc_out: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    plain && rop_q == ROP_NSRC |=> pix_o.data == ~$past(pix_i.src))
    else $error("inverted source code gave wrong pixel");

  // Inverted destination code
  a_rop_ndst_out: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    plain && rop_q == ROP_NDST |=> pix_o.data == ~$past(pix_i.dst))
    else $error("inverted destination code gave wrong pixel");

  // And code
  a_rop_and_out: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    plain && rop_q == ROP_AND |=> pix_o.data == ($past(pix_i.src) & $past(pix_i.dst)))
    else $error("and code gave wrong pixel");

  // Or code
  a_rop_or_out: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    plain && rop_q == ROP_OR |=> pix_o.data == ($past(pix_i.src) | $past(pix_i.dst)))
    else $error("or code gave wrong pixel");

  // Inverted and code
  a_rop_nand_out: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    plain && rop_q == ROP_NAND |=> pix_o.data == ~($past(pix_i.src) & $past(pix_i.dst)))
    else $error("nand code gave wrong pixel");

  // Inverted or code
  a_rop_nor_out: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    plain && rop_q == ROP_NOR |=> pix_o.data == ~($past(pix_i.src) | $past(pix_i.dst)))
    else $error("nor code gave wrong pixel");

  // Equality code
  a_rop_xnor_out: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    plain && rop_q == ROP_XNOR |=> pix_o.data == ~($past(pix_i.src) ^ $past(pix_i.dst)))
    else $error("xnor code gave wrong pixel");

  // Source with inverted destination
  a_rop_sandn_out: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    plain && rop_q == ROP_SANDN |=> pix_o.data == ($past(pix_i.src) & ~$past(pix_i.dst)))
    else $error("source and-not code gave wrong pixel");

  // Inverted source or destination
  a_rop_nsor_out: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    plain && rop_q == ROP_NSOR |=> pix_o.data == (~$past(pix_i.src) | $past(pix_i.dst)))
    else $error("inverted-source or code gave wrong pixel");

  // Source or inverted destination
  a_rop_sorn_out: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    plain && rop_q == ROP_SORN |=> pix_o.data == ($past(pix_i.src) | ~$past(pix_i.dst)))
    else $error("source or-not code gave wrong pixel");

  // Expanded zero bit feeds the background colour
  a_expand_bg_operand: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    pix_valid_i && cexp && !transp && !solid && !pix_i.mono && !pix_i.clip_blk && rop_q == ROP_SRC |=> pix_o.we && pix_o.data == $past(pix_i.bg))
    else $error("expanded background operand wrong");

  // Non-expanded system blits discard to the dword end
  a_plain_dword_skip: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    line_end_i && sys_src && !cexp |=> skip_valid_o && skip_bits_o == ((POS_ZERO - $past(src_bit_pos_i)) & MASK_DWORD))
    else $error("non-expanded discard count wrong");

  // Unlocked extension register takes the write
  a_ext_open_write: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    reg_wr_i && sel_ext && ext_open |=> ext_q == $past(reg_wdata_i[EXT_W-1:0]))
    else $error("unlocked extension write lost");

endmodule

/* File: verif/blit_rop_transparency_ext_test.sv */
// Self-checking testbench for the raster-operation and write-qualification stage
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected %s exp=%h got=%h", nm, e, g); end end
module blit_rop_transparency_ext_test;
  timeunit 1ns;
  timeprecision 1ns;
  import blit_rop_pkg::*;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  localparam logic [15:0] FG = 16'hA5C3;
  localparam logic [15:0] BG = 16'h5A3C;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, autostart_en_i = 1'b1;
  logic blit_done_i = 1'b0, pix_valid_i = 1'b0, line_end_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, blit_mode_control_i = 8'h00;
  logic [7:0] double_buffer_control_i = 8'h20;
  logic [4:0] src_bit_pos_i = 5'h00;
  pix_in_s pix_i = '0;
  logic [7:0] reg_rdata_o;
  logic pix_valid_o, skip_valid_o, disp_buf_sel_o;
  pix_out_s pix_o;
  logic [4:0] skip_bits_o;
  int num_errors = 0, cmp_count = 0, cycle_cnt = 0;
  blit_rop_transparency_ext dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .blit_mode_control_i(blit_mode_control_i), .autostart_en_i(autostart_en_i),
    .double_buffer_control_i(double_buffer_control_i), .blit_done_i(blit_done_i),
    .pix_valid_i(pix_valid_i), .pix_i(pix_i), .pix_valid_o(pix_valid_o), .pix_o(pix_o),
    .line_end_i(line_end_i), .src_bit_pos_i(src_bit_pos_i), .skip_valid_o(skip_valid_o),
    .skip_bits_o(skip_bits_o), .disp_buf_sel_o(disp_buf_sel_o));
  // Engine clock at 20 MHz
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  // ****************************************
  // Shared bus, pixel and line tasks
  // ****************************************
  task automatic end_of_test;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK("reg_rdata_o", e, reg_rdata_o)
  endtask
  // One pixel with its mode; data is only judged when a write is expected
  task automatic px(input logic [7:0] md, input logic [15:0] s, input logic [15:0] d, input logic m,
                    input logic c, input logic b, input logic [15:0] ed, input logic ew);
    @(posedge mclk_i);
    blit_mode_control_i <= md;
    pix_valid_i <= 1'b1;
    pix_i <= '{src: s, dst: d, fg: FG, bg: BG, mono: m, clip_blk: c, bpp16: b};
    @(posedge mclk_i);
    pix_valid_i <= 1'b0;
    #1;
    `CHK("pix_valid_o", 1'b1, pix_valid_o)
    `CHK("pix_o.we", ew, pix_o.we)
    if (ew) `CHK("pix_o.data", ed, pix_o.data)
  endtask
  task automatic sk(input logic [7:0] md, input logic [4:0] pos, input logic ev, input logic [4:0] eb);
    @(posedge mclk_i);
    blit_mode_control_i <= md;
    line_end_i <= 1'b1;
    src_bit_pos_i <= pos;
    @(posedge mclk_i);
    line_end_i <= 1'b0;
    #1;
    `CHK("skip_valid_o", ev, skip_valid_o)
    if (ev) `CHK("skip_bits_o", eb, skip_bits_o)
  endtask
  task automatic bd(input logic [7:0] dbc, input logic ev);
    @(posedge mclk_i);
    double_buffer_control_i <= dbc;
    blit_done_i <= 1'b1;
    @(posedge mclk_i);
    blit_done_i <= 1'b0;
    #1;
    `CHK("disp_buf_sel_o", ev, disp_buf_sel_o)
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    rd(OFF_ROP, 8'h06);
    rd(OFF_EXT, 8'h00);
    rd(OFF_KEYLO, 8'h00);
    rd(OFF_KEYHI, 8'h00);
    rd(8'h20, 8'h00);
    `CHK("disp_buf_sel_o", 1'b0, disp_buf_sel_o)
  endtask
  // Every code against all four source and destination bit pairs
  task automatic t_rop;
    logic [7:0] codes [16] = '{8'h00, 8'h0E, 8'h06, 8'h0D, 8'hD0, 8'h0B, 8'h05, 8'h6D,
                               8'h59, 8'hDA, 8'h90, 8'h95, 8'h50, 8'h09, 8'hD6, 8'hAD};
    logic [3:0] tt [16] = '{4'h0, 4'hF, 4'hA, 4'hC, 4'h3, 4'h5, 4'h8, 4'hE,
                            4'h6, 4'h7, 4'h1, 4'h9, 4'h2, 4'h4, 4'hB, 4'hD};
    logic [15:0] s, d, e;
    s = 16'hFF00;
    d = 16'hF0F0;
    for (int i = 0; i < 16; i++) begin
      for (int b = 0; b < 16; b++) e[b] = tt[i][{s[b], d[b]}];
      wr(OFF_ROP, codes[i]);
      rd(OFF_ROP, codes[i]);
      px(8'h00, s, d, 1'b0, 1'b0, 1'b1, e, 1'b1);
    end
  endtask
  task automatic t_key;
    wr(OFF_ROP, 8'h0D);
    wr(OFF_KEYLO, 8'h34);
    wr(OFF_KEYHI, 8'h12);
    rd(OFF_KEYLO, 8'h34);
    rd(OFF_KEYHI, 8'h12);
    px(8'h08, 16'h1234, 16'h0000, 1'b0, 1'b0, 1'b1, 16'h1234, 1'b0);
    px(8'h08, 16'h1235, 16'h0000, 1'b0, 1'b0, 1'b1, 16'h1235, 1'b1);
    px(8'h08, 16'h3412, 16'h0000, 1'b0, 1'b0, 1'b1, 16'h3412, 1'b1);
    wr(OFF_ROP, 8'h06);
    px(8'h08, 16'h0000, 16'h1234, 1'b0, 1'b0, 1'b1, 16'h1234, 1'b0);
    wr(OFF_ROP, 8'h0D);
    wr(OFF_KEYHI, 8'h34);
    px(8'h08, 16'h3434, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h3434, 1'b0);
    px(8'h00, 16'h3434, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h3434, 1'b1);
  endtask
  task automatic t_expand;
    px(8'h80, 16'h0000, 16'h1111, 1'b1, 1'b0, 1'b1, FG, 1'b1);
    px(8'h80, 16'h0000, 16'h1111, 1'b0, 1'b0, 1'b1, BG, 1'b1);
    px(8'h88, 16'h0000, 16'h1111, 1'b0, 1'b0, 1'b1, BG, 1'b0);
    wr(OFF_EXT, 8'h02);
    px(8'h88, 16'h0000, 16'h1111, 1'b1, 1'b0, 1'b1, FG, 1'b0);
    px(8'h88, 16'h0000, 16'h1111, 1'b0, 1'b0, 1'b1, FG, 1'b1);
    wr(OFF_EXT, 8'h09);
    px(8'h80, 16'h0000, 16'h1111, 1'b1, 1'b1, 1'b1, FG, 1'b1);
    px(8'h80, 16'h0000, 16'h1111, 1'b0, 1'b1, 1'b1, BG, 1'b0);
    wr(OFF_EXT, 8'h01);
    px(8'h80, 16'h0000, 16'h1111, 1'b1, 1'b1, 1'b1, FG, 1'b0);
    wr(OFF_EXT, 8'h04);
    px(8'hC0, 16'h0000, 16'h1111, 1'b0, 1'b0, 1'b1, FG, 1'b1);
  endtask
  task automatic t_ext;
    @(posedge mclk_i);
    autostart_en_i <= 1'b0;
    wr(OFF_EXT, 8'h1F);
    rd(OFF_EXT, 8'h04);
    @(posedge mclk_i);
    autostart_en_i <= 1'b1;
    double_buffer_control_i <= 8'h00;
    wr(OFF_EXT, 8'h1F);
    rd(OFF_EXT, 8'h04);
    @(posedge mclk_i);
    double_buffer_control_i <= 8'h20;
    wr(OFF_EXT, 8'hFF);
    rd(OFF_EXT, 8'h1F);
    wr(OFF_EXT, 8'h10);
    bd(8'h27, 1'b1);
    bd(8'h27, 1'b0);
    bd(8'h26, 1'b0);
    wr(OFF_EXT, 8'h00);
    bd(8'h27, 1'b0);
  endtask
  task automatic t_skip;
    sk(8'h84, 5'd5, 1'b1, 5'd3);
    sk(8'h84, 5'd8, 1'b1, 5'd0);
    sk(8'h04, 5'd8, 1'b1, 5'd24);
    wr(OFF_EXT, 8'h01);
    sk(8'h84, 5'd5, 1'b1, 5'd27);
    sk(8'h84, 5'd1, 1'b1, 5'd31);
    sk(8'h04, 5'd16, 1'b1, 5'd16);
    sk(8'h80, 5'd5, 1'b0, 5'd0);
  endtask
  // ****************************************
  // Main sequence and hang guard
  // ****************************************
  initial begin
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_rop();
    t_key();
    t_expand();
    t_ext();
    t_skip();
    end_of_test();
  end
  always @(posedge mclk_i) begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == 3000) begin
      num_errors++;
      end_of_test();
    end
  end
endmodule
